// file: crf_core.sv
`timescale 1ns/1ps
// Top: registers, program counter, flags and address generation
module crf_core (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // Register write
    input  wire crf_pkg::crf_wr_e wr_kind,
    input  wire logic [3:0]      wr_num,
    input  wire logic [15:0]     wr_data,
    // Register reads (registered, two cycles later)
    input  wire logic [3:0]      rd_a_num,
    input  wire logic [3:0]      rd_b_num,
    output logic      [15:0]     rd_a_word,
    output logic      [7:0]      rd_a_byte,
    output logic      [15:0]     rd_b_word,
    output logic      [7:0]      rd_b_byte,
    output logic      [15:0]     stack_pointer_alias,
    // Address generation request
    input  wire logic            ag_valid,
    input  wire crf_pkg::crf_am_e ag_mode,
    input  wire logic [2:0]      ag_reg,
    input  wire logic            ag_word,
    input  wire logic [15:0]     ag_ext,
    output logic                 ag_done,
    output logic      [15:0]     ag_addr,
    // Program counter control
    input  wire crf_pkg::crf_pc_e pc_op,
    input  wire logic [15:0]     pc_load_val,
    input  wire logic [7:0]      pc_disp,
    output logic      [15:0]     pc_out,
    // Flag update
    input  wire crf_pkg::crf_fo_e flag_op,
    input  wire logic            flag_word,
    input  wire logic [15:0]     op_a,
    input  wire logic [15:0]     op_b,
    input  wire logic            op_carry_in,
    input  wire logic [15:0]     logic_result,
    input  wire logic            shift_out,
    input  wire logic            bit_value,
    input  wire logic [7:0]      flag_imm,
    input  wire logic            irq_entry,
    output logic      [7:0]      condition_flags,
    // Interrupt gating
    input  wire logic            irq_maskable_req,
    input  wire logic            irq_nmi_req,
    output logic                 irq_take
);
    localparam int AW = 3;

    logic [15:0] mem_a;
    logic [15:0] mem_b;
    logic [15:0] sp_rd;
    logic        a_lo_reg;
    logic        b_lo_reg;
    logic [15:0] pc_reg;
    logic [7:0]  flags_reg;
    logic        mem_hi_we;
    logic        mem_lo_we;
    logic [2:0]  mem_widx;
    logic [15:0] mem_wdata;
    logic [15:0] ag_base;
    logic [15:0] ag_raw;
    logic [15:0] ag_step;
    logic        ag_upd;
    logic [15:0] ag_upd_val;
    logic        ag_drop;
    logic        ag_v1_reg;
    crf_pkg::crf_am_e ag_mode_reg;
    logic        ag_word_reg;
    logic [2:0]  ag_reg_reg;
    logic [15:0] ag_ext_reg;
    logic [15:0] pc_snap_reg;
    logic [15:0] pc_next;

    // Auto-update wins over a plain write
    always_comb begin
        ag_step    = ag_word_reg ? crf_pkg::STEP_WORD : crf_pkg::STEP_BYTE;
        ag_upd     = ag_v1_reg && (ag_mode_reg == crf_pkg::CRF_AM_POSTINC
                                   || ag_mode_reg == crf_pkg::CRF_AM_PREDEC);
        ag_drop    = ag_valid && (ag_mode == crf_pkg::CRF_AM_POSTINC
                                  || ag_mode == crf_pkg::CRF_AM_PREDEC);
        ag_upd_val = (ag_mode_reg == crf_pkg::CRF_AM_POSTINC) ? ag_base + ag_step
                                                              : ag_base - ag_step;
        mem_widx   = wr_num[2:0];
        mem_wdata  = {wr_data[7:0], wr_data[7:0]};
        mem_hi_we  = 1'b0;
        mem_lo_we  = 1'b0;
        if (ag_upd) begin
            mem_widx  = ag_reg_reg;
            mem_wdata = ag_upd_val;
            mem_hi_we = 1'b1;
            mem_lo_we = 1'b1;
        end else if (ag_drop) begin
            mem_hi_we = 1'b0;
        end else if (wr_kind == crf_pkg::CRF_WR_WORD) begin
            mem_wdata = wr_data;
            mem_hi_we = 1'b1;
            mem_lo_we = 1'b1;
        end else if (wr_kind == crf_pkg::CRF_WR_HIGH) begin
            mem_hi_we = 1'b1;
        end else if (wr_kind == crf_pkg::CRF_WR_LOW) begin
            mem_lo_we = 1'b1;
        end
    end

    crf_regmem #(
        .DEPTH (crf_pkg::NUM_WREGS),
        .AW    (AW)
    ) u_mem (
        .clk       (clk),
        .wr_idx    (mem_widx),
        .wr_hi     (mem_hi_we),
        .wr_lo     (mem_lo_we),
        .wr_data   (mem_wdata),
        .rd_a_idx  (rd_a_num[2:0]),
        .rd_b_idx  (ag_valid ? ag_reg : rd_b_num[2:0]),
        .rd_a_data (mem_a),
        .rd_b_data (mem_b)
    );

    // Second copy: address base and stack pointer
    crf_regmem #(
        .DEPTH (crf_pkg::NUM_WREGS),
        .AW    (AW)
    ) u_sp (
        .clk       (clk),
        .wr_idx    (mem_widx),
        .wr_hi     (mem_hi_we),
        .wr_lo     (mem_lo_we),
        .wr_data   (mem_wdata),
        .rd_a_idx  (crf_pkg::SP_INDEX),
        .rd_b_idx  (ag_reg),
        .rd_a_data (sp_rd),
        .rd_b_data (ag_base)
    );

    always_ff @(posedge clk) begin
        a_lo_reg <= rd_a_num[3];
        b_lo_reg <= rd_b_num[3];
    end

    // Data reads: word, or one byte half
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_a_word           <= 16'h0000;
            rd_a_byte           <= 8'h00;
            rd_b_word           <= 16'h0000;
            rd_b_byte           <= 8'h00;
            stack_pointer_alias <= 16'h0000;
        end else begin
            rd_a_word           <= mem_a;
            rd_a_byte           <= a_lo_reg ? mem_a[7:0] : mem_a[15:8];
            rd_b_word           <= mem_b;
            rd_b_byte           <= b_lo_reg ? mem_b[7:0] : mem_b[15:8];
            stack_pointer_alias <= sp_rd;
        end
    end

    // Address results land two edges after the request
    always_ff @(posedge clk) begin
        if (srst) begin
            ag_v1_reg   <= 1'b0;
            ag_reg_reg  <= 3'h0;
            ag_mode_reg <= crf_pkg::CRF_AM_INDIRECT;
            ag_word_reg <= 1'b0;
            ag_ext_reg  <= 16'h0000;
            pc_snap_reg <= 16'h0000;
        end else begin
            ag_v1_reg   <= ag_valid;
            ag_reg_reg  <= ag_reg;
            ag_mode_reg <= ag_mode;
            ag_word_reg <= ag_word;
            ag_ext_reg  <= ag_ext;
            pc_snap_reg <= pc_reg;
        end
    end

    always_comb begin
        case (ag_mode_reg)
            crf_pkg::CRF_AM_DISP:    ag_raw = ag_base + ag_ext_reg;
            crf_pkg::CRF_AM_PREDEC:  ag_raw = ag_upd_val;
            crf_pkg::CRF_AM_ABS8:    ag_raw = {crf_pkg::SHORT_ABS_PAGE, ag_ext_reg[7:0]};
            crf_pkg::CRF_AM_ABS16:   ag_raw = ag_ext_reg;
            crf_pkg::CRF_AM_PCREL:   ag_raw = pc_snap_reg
                                            + {{8{ag_ext_reg[7]}}, ag_ext_reg[7:0]};
            crf_pkg::CRF_AM_MEMIND:  ag_raw = {crf_pkg::INDIRECT_PAGE, ag_ext_reg[7:0]};
            default:                 ag_raw = ag_base;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ag_done <= 1'b0;
            ag_addr <= 16'h0000;
        end else begin
            ag_done <= ag_v1_reg;
            if (ag_v1_reg) begin
                // Word access and branch targets ignore bit zero
                ag_addr <= (ag_word_reg || ag_mode_reg == crf_pkg::CRF_AM_PCREL
                            || ag_mode_reg == crf_pkg::CRF_AM_MEMIND)
                           ? {ag_raw[15:1], 1'b0} : ag_raw;
            end
        end
    end

    // Program counter
    always_comb begin
        case (pc_op)
            crf_pkg::CRF_PC_LOAD,
            crf_pkg::CRF_PC_VECTOR: pc_next = {pc_load_val[15:1], 1'b0};
            crf_pkg::CRF_PC_REL:    pc_next = pc_reg
                                              + {{8{pc_disp[7]}}, pc_disp[7:1], 1'b0};
            default:                pc_next = pc_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_reg <= crf_pkg::PC_RST;
            pc_out <= crf_pkg::PC_RST;
        end else begin
            pc_reg <= pc_next;
            pc_out <= {pc_next[15:1], 1'b0};
        end
    end

    // Flag computation
    logic [16:0] sum17;
    logic [4:0]  lo_nib;
    logic [12:0] lo_12;
    logic [7:0]  flags_next;
    logic        is_sub;
    logic [15:0] b_eff;
    logic [15:0] res;

    always_comb begin
        is_sub = (flag_op == crf_pkg::CRF_FO_SUB);
        b_eff  = is_sub ? ~op_b : op_b;
        sum17  = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, op_carry_in ^ is_sub};
        lo_nib = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, op_carry_in ^ is_sub};
        lo_12  = {1'b0, op_a[11:0]} + {1'b0, b_eff[11:0]} + {12'h000, op_carry_in ^ is_sub};
        res    = flag_word ? sum17[15:0] : {8'h00, sum17[7:0]};
        flags_next = flags_reg;
        case (flag_op)
            crf_pkg::CRF_FO_ADD, crf_pkg::CRF_FO_SUB: begin
                flags_next[crf_pkg::FLG_H] = (flag_word ? lo_12[12] : lo_nib[4]) ^ is_sub;
                flags_next[crf_pkg::FLG_N] = flag_word ? res[15] : res[7];
                flags_next[crf_pkg::FLG_Z] = flag_word ? (res == 16'h0000)
                                                       : (res[7:0] == 8'h00);
                flags_next[crf_pkg::FLG_V] = flag_word
                    ? (op_a[15] == b_eff[15]) && (res[15] != op_a[15])
                    : (op_a[7] == b_eff[7]) && (res[7] != op_a[7]);
                flags_next[crf_pkg::FLG_C] = (flag_word ? sum17[16]
                    : (sum17[8] ^ op_a[8] ^ b_eff[8])) ^ is_sub;
            end
            crf_pkg::CRF_FO_LOGIC: begin
                flags_next[crf_pkg::FLG_N] = flag_word ? logic_result[15] : logic_result[7];
                flags_next[crf_pkg::FLG_Z] = flag_word ? (logic_result == 16'h0000)
                                                       : (logic_result[7:0] == 8'h00);
                flags_next[crf_pkg::FLG_V] = 1'b0;
            end
            crf_pkg::CRF_FO_SHIFT:  flags_next[crf_pkg::FLG_C] = shift_out;
            crf_pkg::CRF_FO_BITACC: flags_next[crf_pkg::FLG_C] = bit_value;
            crf_pkg::CRF_FO_LOAD:   flags_next = flag_imm;
            crf_pkg::CRF_FO_AND:    flags_next = flags_reg & flag_imm;
            crf_pkg::CRF_FO_OR:     flags_next = flags_reg | flag_imm;
            crf_pkg::CRF_FO_XOR:    flags_next = flags_reg ^ flag_imm;
            default:                flags_next = flags_reg;
        endcase
        if (irq_entry) begin
            flags_next[crf_pkg::FLG_I] = 1'b1;
        end
    end

    // Only the mask bit has a defined reset value; others are zeroed for determinism
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_reg <= crf_pkg::FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            condition_flags <= crf_pkg::FLAGS_RST;
            irq_take        <= 1'b0;
        end else begin
            condition_flags <= flags_next;
            irq_take        <= irq_nmi_req
                               || (irq_maskable_req && !flags_reg[crf_pkg::FLG_I]);
        end
    end
endmodule

// file: crf_core_chk.sv
// Checker: properties on the core ports
`timescale 1ns/1ps
module crf_core_chk (
    // Clock and reset
    input wire logic             clk,
    input wire logic             srst,
    // Address generation and program counter
    input wire logic             ag_valid,
    input wire crf_pkg::crf_am_e ag_mode,
    input wire logic             ag_word,
    input wire logic [15:0]      ag_ext,
    input wire logic             ag_done,
    input wire logic [15:0]      ag_addr,
    input wire logic [15:0]      pc_out,
    // Flags and interrupts
    input wire crf_pkg::crf_fo_e flag_op,
    input wire logic             flag_word,
    input wire logic [15:0]      logic_result,
    input wire logic [7:0]       flag_imm,
    input wire logic             irq_entry,
    input wire logic [7:0]       condition_flags,
    input wire logic             irq_maskable_req,
    input wire logic             irq_nmi_req,
    input wire logic             irq_take
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Reset itself is the cause here, so this one must not be disabled by it
    property p_reset_state;
        disable iff (1'b0) srst |=> condition_flags == 8'h80 && pc_out == 16'h0000;
    endproperty
    property p_pc_even;
        pc_out[0] == 1'b0;
    endproperty
    property p_irq_gate;
        !$past(srst) |-> irq_take == $past(irq_nmi_req | (irq_maskable_req & ~condition_flags[7]));
    endproperty
    property p_entry_mask;
        irq_entry |=> condition_flags[7];
    endproperty
    property p_ag_latency;
        ag_valid |-> ##2 ag_done;
    endproperty
    property p_short_abs;
        ag_valid && ag_mode == crf_pkg::CRF_AM_ABS8 |-> ##2 ag_addr == {8'hff, $past(ag_ext[7:0], 2)};
    endproperty
    property p_mem_indirect;
        ag_valid && ag_mode == crf_pkg::CRF_AM_MEMIND |-> ##2 ag_addr[15:8] == 8'h00;
    endproperty
    property p_word_even;
        ag_valid && ag_word |-> ##2 !ag_addr[0];
    endproperty
    property p_logic_sign;
        flag_op == crf_pkg::CRF_FO_LOGIC && !flag_word |=> condition_flags[3] ==
            $past(logic_result[7]) && condition_flags[2] == ($past(logic_result[7:0]) == 8'h00);
    endproperty
    property p_xor_flags;
        flag_op == crf_pkg::CRF_FO_XOR && !irq_entry |=>
            condition_flags == ($past(condition_flags) ^ $past(flag_imm));
    endproperty

    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    a_pc_even: assert property (p_pc_even) else $error("odd program counter");
    a_irq_gate: assert property (p_irq_gate) else $error("wrong interrupt gating");
    a_entry_mask: assert property (p_entry_mask) else $error("mask not set on entry");
    a_ag_latency: assert property (p_ag_latency) else $error("address not done");
    a_short_abs: assert property (p_short_abs) else $error("short address wrong");
    a_mem_indirect: assert property (p_mem_indirect) else $error("indirect off page");
    a_word_even: assert property (p_word_even) else $error("odd word address");
    a_logic_sign: assert property (p_logic_sign) else $error("sign or zero wrong");
    a_xor_flags: assert property (p_xor_flags) else $error("flag xor wrong");

    c_ag: cover property (ag_done);
    c_irq: cover property (irq_take && irq_maskable_req && !irq_nmi_req);
    c_load: cover property (flag_op == crf_pkg::CRF_FO_LOAD);
endmodule

bind crf_core crf_core_chk u_crf_core_chk (
    .clk, .srst, .ag_valid, .ag_mode, .ag_word, .ag_ext, .ag_done, .ag_addr, .pc_out,
    .flag_op, .flag_word, .logic_result, .flag_imm, .irq_entry, .condition_flags,
    .irq_maskable_req, .irq_nmi_req, .irq_take
);

// file: crf_mem_model.sv
// Partner model: low-page word memory that answers indirect target fetches
`timescale 1ns/1ps
module crf_mem_model (
    // Address from the core
    input  wire logic [15:0] addr,
    // Word read back
    output logic      [15:0] rdata
);
    logic [15:0] mem [128];

    // Odd contents, so a fetched target still has to lose its bit zero
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 16'h4001 + 16'(i) * 16'h0102;
        end
    end

    // Word access ignores address bit zero; above the low page the inverted address is returned
    always_comb begin
        if (addr[15:8] == 8'h00) begin
            rdata = mem[addr[7:1]];
        end else begin
            rdata = ~addr;
        end
    end
endmodule

// file: crf_pkg.sv
// Package: constants and types of the processor register file and address generator
// Behaviour
// - Sixteen byte registers or eight word registers
// - Address reads full word; data by byte/word
// - Register seven is the stack pointer
// - Program counter sixteen bits, bit zero zero
// - Mask flag blocks maskable interrupts; set on entry
// - Flag bits six and four are user bits
// - Byte arithmetic half-carry from bit three
// - Word arithmetic half-carry from bit eleven
// - Negative flag copies result sign bit
// - Zero flag set on all-zero result
// - Overflow flag set on arithmetic overflow
// - Carry from add, shift, bit accumulator
// - Flags loadable, storable, and/or/xor-modifiable
// - Reset loads vector, sets mask only; here reset clears the counter to PC_RST
// - Register-direct operands byte except word ops
// - Displacement mode: register plus sixteen-bit displacement
// - Post-increment by one or two after access
// - Pre-decrement by one or two before access
// - Short absolute forces upper byte to ones
// - Relative branch add_small_const sign-extended displacement
// - Memory indirect selects word in low page
// - Odd word address cleared to even
package crf_pkg;
    localparam int          WORD_W     = 16;
    localparam int          BYTE_W     = 8;
    localparam int          NUM_WREGS  = 8;
    localparam logic [2:0]  SP_INDEX   = 3'h7;
    // Flag bit positions
    localparam int          FLG_I      = 7;
    localparam int          FLG_U1     = 6;
    localparam int          FLG_H      = 5;
    localparam int          FLG_U0     = 4;
    localparam int          FLG_N      = 3;
    localparam int          FLG_Z      = 2;
    localparam int          FLG_V      = 1;
    localparam int          FLG_C      = 0;
    localparam logic [7:0]  FLAGS_RST  = 8'h80;
    localparam logic [15:0] PC_RST     = 16'h0000;
    localparam logic [7:0]  SHORT_ABS_PAGE = 8'hff;
    localparam logic [7:0]  INDIRECT_PAGE  = 8'h00;
    localparam logic [15:0] STEP_BYTE  = 16'h0001;
    localparam logic [15:0] STEP_WORD  = 16'h0002;

    // Register write width
    typedef enum logic [1:0] {
        CRF_WR_NONE,
        CRF_WR_HIGH,
        CRF_WR_LOW,
        CRF_WR_WORD
    } crf_wr_e;

    // Address generation modes
    typedef enum logic [2:0] {
        CRF_AM_INDIRECT,
        CRF_AM_DISP,
        CRF_AM_POSTINC,
        CRF_AM_PREDEC,
        CRF_AM_ABS8,
        CRF_AM_ABS16,
        CRF_AM_PCREL,
        CRF_AM_MEMIND
    } crf_am_e;

    // Flag update operations
    typedef enum logic [3:0] {
        CRF_FO_NONE,
        CRF_FO_ADD,
        CRF_FO_SUB,
        CRF_FO_LOGIC,
        CRF_FO_SHIFT,
        CRF_FO_BITACC,
        CRF_FO_LOAD,
        CRF_FO_AND,
        CRF_FO_OR,
        CRF_FO_XOR
    } crf_fo_e;

    typedef enum logic [1:0] {
        CRF_PC_HOLD,
        CRF_PC_LOAD,
        CRF_PC_REL,
        CRF_PC_VECTOR
    } crf_pc_e;
endpackage

// file: crf_regmem.sv
`timescale 1ns/1ps
// Eight-entry word register memory with byte-lane writes and registered reads
module crf_regmem #(
    parameter int DEPTH  = 8,
    parameter int AW     = 3
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic          wr_hi,
    input  wire logic          wr_lo,
    input  wire logic [15:0]   wr_data,
    // Read ports
    input  wire logic [AW-1:0] rd_a_idx,
    input  wire logic [AW-1:0] rd_b_idx,
    output logic      [15:0]   rd_a_data,
    output logic      [15:0]   rd_b_data
);
    logic [15:0] mem_reg [DEPTH];

    // Contents are left undefined by reset, so the array has no reset term
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge clk) begin
                if (wr_hi && wr_idx == AW'(i)) begin
                    mem_reg[i][15:8] <= wr_data[15:8];
                end
                if (wr_lo && wr_idx == AW'(i)) begin
                    mem_reg[i][7:0] <= wr_data[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        rd_a_data <= mem_reg[rd_a_idx];
        rd_b_data <= mem_reg[rd_b_idx];
    end
endmodule

// file: testbench.sv
// Testbench for the register file core
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        crf_pkg::crf_fo_e op;
        logic             w;
        logic [15:0]      a;
        logic [15:0]      b;
        logic             ci;
        logic [7:0]       exp;
    } crf_row_s;

    // Immediate rows carry the mask value in b; state carries from row to row
    localparam crf_row_s ROWS [13] = '{
        '{crf_pkg::CRF_FO_LOAD, 1'b0, 16'h0000, 16'h005a, 1'b0, 8'h5a},
        '{crf_pkg::CRF_FO_OR, 1'b0, 16'h0000, 16'h0081, 1'b0, 8'hdb},
        '{crf_pkg::CRF_FO_AND, 1'b0, 16'h0000, 16'h007f, 1'b0, 8'h5b},
        '{crf_pkg::CRF_FO_XOR, 1'b0, 16'h0000, 16'h0050, 1'b0, 8'h0b},
        '{crf_pkg::CRF_FO_LOAD, 1'b0, 16'h0000, 16'h0000, 1'b0, 8'h00},
        '{crf_pkg::CRF_FO_ADD, 1'b0, 16'h000f, 16'h0001, 1'b0, 8'h20},
        '{crf_pkg::CRF_FO_ADD, 1'b0, 16'h0080, 16'h0080, 1'b0, 8'h07},
        '{crf_pkg::CRF_FO_ADD, 1'b0, 16'h000e, 16'h0001, 1'b1, 8'h20},
        '{crf_pkg::CRF_FO_SUB, 1'b0, 16'h0000, 16'h0001, 1'b0, 8'h29},
        '{crf_pkg::CRF_FO_SUB, 1'b0, 16'h0080, 16'h0001, 1'b0, 8'h22},
        '{crf_pkg::CRF_FO_ADD, 1'b1, 16'h0800, 16'h0800, 1'b0, 8'h20},
        '{crf_pkg::CRF_FO_ADD, 1'b1, 16'hffff, 16'h0001, 1'b0, 8'h25},
        '{crf_pkg::CRF_FO_SUB, 1'b1, 16'h8000, 16'h0001, 1'b0, 8'h22}
    };

    logic             clk, srst, ag_valid, ag_word, ag_done, flag_word, op_carry_in;
    logic             shift_out, bit_value, irq_entry, irq_maskable_req, irq_nmi_req, irq_take;
    logic [2:0]       ag_reg;
    logic [3:0]       wr_num, rd_a_num, rd_b_num;
    logic [7:0]       rd_a_byte, rd_b_byte, pc_disp, flag_imm, condition_flags;
    logic [15:0]      wr_data, ag_ext, pc_load_val, op_a, op_b, logic_result, mem_word;
    logic [15:0]      rd_a_word, rd_b_word, stack_pointer_alias, ag_addr, pc_out;
    crf_pkg::crf_wr_e wr_kind;
    crf_pkg::crf_am_e ag_mode;
    crf_pkg::crf_pc_e pc_op;
    crf_pkg::crf_fo_e flag_op;
    int               num_errors = 0;
    int               n_compared = 0;

    crf_core u_crf_core (
        .clk, .srst, .wr_kind, .wr_num, .wr_data, .rd_a_num, .rd_b_num, .rd_a_word,
        .rd_a_byte, .rd_b_word, .rd_b_byte, .stack_pointer_alias, .ag_valid, .ag_mode,
        .ag_reg, .ag_word, .ag_ext, .ag_done, .ag_addr, .pc_op, .pc_load_val, .pc_disp,
        .pc_out, .flag_op, .flag_word, .op_a, .op_b, .op_carry_in, .logic_result,
        .shift_out, .bit_value, .flag_imm, .irq_entry, .condition_flags,
        .irq_maskable_req, .irq_nmi_req, .irq_take
    );
    crf_mem_model u_crf_mem_model (.addr(ag_addr), .rdata(mem_word));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input crf_pkg::crf_wr_e k, input logic [3:0] n, input logic [15:0] d);
        wr_kind = k;
        wr_num = n;
        wr_data = d;
        tick();
        wr_kind = crf_pkg::CRF_WR_NONE;
    endtask

    // Reads land two edges after select
    task automatic rd(input logic [3:0] a, input logic [3:0] b);
        rd_a_num = a;
        rd_b_num = b;
        repeat (3) tick();
    endtask

    task automatic fop(input crf_pkg::crf_fo_e op, input logic w, input logic [15:0] a,
                       input logic [15:0] b, input logic ci);
        flag_op = op;
        flag_word = w;
        op_a = a;
        op_b = b;
        op_carry_in = ci;
        flag_imm = b[7:0];
        logic_result = a;
        tick();
        flag_op = crf_pkg::CRF_FO_NONE;
    endtask

    task automatic ag(input crf_pkg::crf_am_e m, input logic [2:0] r, input logic w,
                      input logic [15:0] x, input logic [15:0] exp);
        int k = 0;
        ag_valid = 1'b1;
        ag_mode = m;
        ag_reg = r;
        ag_word = w;
        ag_ext = x;
        tick();
        ag_valid = 1'b0;
        wr_kind = crf_pkg::CRF_WR_NONE;
        while (ag_done !== 1'b1 && k < 4) begin
            tick();
            k++;
        end
        cmp(16'(ag_done), 16'h0001);
        cmp(ag_addr, exp);
    endtask

    task automatic pcop(input crf_pkg::crf_pc_e op, input logic [15:0] v, input logic [7:0] d);
        pc_op = op;
        pc_load_val = v;
        pc_disp = d;
        tick();
        pc_op = crf_pkg::CRF_PC_HOLD;
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        results();
    end

    initial begin
        srst = 1'b1;
        {ag_valid, ag_word, flag_word, op_carry_in, shift_out, bit_value} = 6'h00;
        {irq_entry, irq_maskable_req, irq_nmi_req, ag_reg, wr_num, rd_a_num, rd_b_num} = 18'h0;
        {pc_disp, flag_imm, wr_data, ag_ext, pc_load_val, op_a, op_b, logic_result} = 112'h0;
        wr_kind = crf_pkg::CRF_WR_NONE;
        ag_mode = crf_pkg::CRF_AM_INDIRECT;
        pc_op = crf_pkg::CRF_PC_HOLD;
        flag_op = crf_pkg::CRF_FO_NONE;
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        cmp(16'(condition_flags), 16'h0080);
        foreach (ROWS[i]) begin
            fop(ROWS[i].op, ROWS[i].w, ROWS[i].a, ROWS[i].b, ROWS[i].ci);
            cmp(16'(condition_flags), 16'(ROWS[i].exp));
        end
        shift_out = 1'b1;
        fop(crf_pkg::CRF_FO_SHIFT, 1'b0, 16'h0000, 16'h0000, 1'b0);
        cmp(16'(condition_flags[0]), 16'h0001);
        fop(crf_pkg::CRF_FO_BITACC, 1'b0, 16'h0000, 16'h0000, 1'b0);
        cmp(16'(condition_flags[0]), 16'h0000);
        fop(crf_pkg::CRF_FO_LOGIC, 1'b0, 16'hff00, 16'h0000, 1'b0);
        cmp(16'(condition_flags[3:2]), 16'h0001);
        $display("flag cases done");
        irq_maskable_req = 1'b1;
        tick();
        cmp({15'h0000, irq_take}, 16'h0001);
        irq_entry = 1'b1;
        tick();
        irq_entry = 1'b0;
        tick();
        cmp({14'h0000, condition_flags[7], irq_take}, 16'h0002);
        irq_nmi_req = 1'b1;
        tick();
        cmp({15'h0000, irq_take}, 16'h0001);
        irq_nmi_req = 1'b0;
        irq_maskable_req = 1'b0;
        $display("interrupt gating done");
        wr(crf_pkg::CRF_WR_WORD, 4'h1, 16'h1234);
        wr(crf_pkg::CRF_WR_HIGH, 4'h1, 16'h00ab);
        wr(crf_pkg::CRF_WR_LOW, 4'h9, 16'h00cd);
        wr(crf_pkg::CRF_WR_WORD, 4'h2, 16'h1000);
        wr(crf_pkg::CRF_WR_WORD, 4'h3, 16'h2000);
        wr(crf_pkg::CRF_WR_WORD, 4'h7, 16'hfffe);
        wr(crf_pkg::CRF_WR_WORD, 4'h5, 16'h1111);
        rd(4'h1, 4'h9);
        cmp(rd_a_word, 16'habcd);
        cmp({rd_a_byte, rd_b_byte}, 16'habcd);
        cmp(stack_pointer_alias, 16'hfffe);
        ag(crf_pkg::CRF_AM_POSTINC, 3'h2, 1'b1, 16'h0000, 16'h1000);
        // A plain write beside a post-increment request is dropped
        wr_kind = crf_pkg::CRF_WR_WORD;
        wr_num = 4'h5;
        wr_data = 16'h7777;
        ag(crf_pkg::CRF_AM_POSTINC, 3'h2, 1'b0, 16'h0000, 16'h1002);
        ag(crf_pkg::CRF_AM_PREDEC, 3'h3, 1'b1, 16'h0000, 16'h1ffe);
        ag(crf_pkg::CRF_AM_PREDEC, 3'h3, 1'b0, 16'h0000, 16'h1ffd);
        rd(4'h2, 4'h5);
        cmp(rd_a_word, 16'h1003);
        cmp(rd_b_word, 16'h1111);
        rd(4'h3, 4'h3);
        cmp(rd_a_word, 16'h1ffd);
        ag(crf_pkg::CRF_AM_DISP, 3'h2, 1'b1, 16'h0010, 16'h1012);
        ag(crf_pkg::CRF_AM_DISP, 3'h2, 1'b0, 16'h0010, 16'h1013);
        ag(crf_pkg::CRF_AM_INDIRECT, 3'h1, 1'b1, 16'h0000, 16'habcc);
        ag(crf_pkg::CRF_AM_ABS8, 3'h0, 1'b0, 16'h0034, 16'hff34);
        ag(crf_pkg::CRF_AM_ABS16, 3'h0, 1'b0, 16'h5678, 16'h5678);
        ag(crf_pkg::CRF_AM_MEMIND, 3'h0, 1'b1, 16'h0080, 16'h0080);
        pcop(crf_pkg::CRF_PC_LOAD, mem_word, 8'h00);
        cmp(pc_out, 16'h8080);
        pcop(crf_pkg::CRF_PC_LOAD, 16'h0100, 8'h00);
        ag(crf_pkg::CRF_AM_PCREL, 3'h0, 1'b0, 16'h00fe, 16'h00fe);
        pcop(crf_pkg::CRF_PC_REL, 16'h0000, 8'h80);
        cmp(pc_out, 16'h0080);
        pcop(crf_pkg::CRF_PC_REL, 16'h0000, 8'h7f);
        cmp(pc_out, 16'h00fe);
        $display("registers and addressing done");
        fop(crf_pkg::CRF_FO_LOAD, 1'b0, 16'h0000, 16'h007f, 1'b0);
        srst = 1'b1;
        tick();
        srst = 1'b0;
        cmp(16'(condition_flags), 16'h0080);
        cmp(pc_out, 16'h0000);
        pcop(crf_pkg::CRF_PC_VECTOR, 16'h0040, 8'h00);
        cmp(pc_out, 16'h0040);
        $display("reset cases done");
        results();
    end
endmodule
